/* File: rtl/dac_load_map.vh */
`ifndef DAC_LOAD_MAP_VH
`define DAC_LOAD_MAP_VH

// ----------------------------------------
// Converter count and data widths
// ----------------------------------------
`define NUM_DAC 4
`define SEL_W 2
`define WORD_W 16
`define BYTE_W 8

// ----------------------------------------
// Timing (ns) and derived cycle counts at 100 MHz
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define SETUP_NS 50
`define SETUP_CYC 4'h5
`define STROBE_NS 100
`define STROBE_CYC 4'hA
`define HOLD_NS 50
`define HOLD_CYC 4'h5
`define UPDATE_NS 100
`define UPDATE_CYC 4'hA
`define SKEW_NS 100
`define SKEW_CYC 4'hA
`define CNT_W 4

// ----------------------------------------
// Reset values of pins
// ----------------------------------------
`define SEL_IDLE 4'hF
`define STROBE_IDLE 1'b1
`define LATCH_IDLE 1'b1
`define UPDATE_IDLE 1'b0

`endif

/* File: rtl/dual_rank_dac_load_sequencer.v */
`timescale 1ns/1ps
`include "dac_load_map.vh"

module dual_rank_dac_load_sequencer (
    input wire clk_i,
    input wire reset_i,
    input wire load_valid_i,
    input wire [`SEL_W-1:0] load_sel_i,
    input wire [`WORD_W-1:0] load_data_i,
    input wire byte_mode_i,
    input wire update_valid_i,
    output reg load_ready_o,
    output reg done_o,
    output reg [`WORD_W-1:0] bus_data_o,
    output reg [`NUM_DAC-1:0] decoded_select_n_o,
    output reg first_rank_load_n_o,
    output reg byte_latch_en_n_o,
    output reg output_update_o
);

// ----------------------------------------
// States
// ----------------------------------------
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_HI_SETUP = 3'h1;
localparam [2:0] ST_HI_LATCH = 3'h2;
localparam [2:0] ST_SETUP = 3'h3;
localparam [2:0] ST_STROBE = 3'h4;
localparam [2:0] ST_HOLD = 3'h5;
localparam [2:0] ST_UPDATE = 3'h6;
localparam [2:0] ST_SKEW = 3'h7;

// ----------------------------------------
// Phase lengths in clock cycles
// ----------------------------------------
// Fixed bus timing, so the host never stretches its cycle
localparam [`CNT_W-1:0] SETUP_C = `SETUP_CYC;
localparam [`CNT_W-1:0] STROBE_C = `STROBE_CYC;
localparam [`CNT_W-1:0] HOLD_C = `HOLD_CYC;
localparam [`CNT_W-1:0] UPDATE_C = `UPDATE_CYC;
localparam [`CNT_W-1:0] SKEW_C = `SKEW_CYC;
localparam [`CNT_W-1:0] CNT_ZERO = {`CNT_W{1'b0}};
localparam [`CNT_W-1:0] CNT_ONE = {{(`CNT_W-1){1'b0}}, 1'b1};

// ----------------------------------------
// Helper functions
// ----------------------------------------
// Active-low select, only the addressed converter low
function [`NUM_DAC-1:0] one_low;
    input [`SEL_W-1:0] idx;
    begin
        one_low = ~({{(`NUM_DAC-1){1'b0}}, 1'b1} << idx);
    end
endfunction

// Byte placed on the low lines, upper lines zero
function [`WORD_W-1:0] byte_on_bus;
    input [`BYTE_W-1:0] b;
    begin
        byte_on_bus = {{(`WORD_W-`BYTE_W){1'b0}}, b};
    end
endfunction

// Counter preload on entry to a state; zero marks the last cycle
function [`CNT_W-1:0] phase_len;
    input [2:0] st;
    begin
        case (st)
            ST_HI_SETUP: begin
                phase_len = SETUP_C - CNT_ONE;
            end
            ST_HI_LATCH: begin
                phase_len = STROBE_C - CNT_ONE;
            end
            ST_SETUP: begin
                phase_len = SETUP_C - CNT_ONE;
            end
            ST_STROBE: begin
                phase_len = STROBE_C - CNT_ONE;
            end
            ST_HOLD: begin
                phase_len = HOLD_C - CNT_ONE;
            end
            ST_UPDATE: begin
                phase_len = UPDATE_C - CNT_ONE;
            end
            ST_SKEW: begin
                phase_len = SKEW_C - CNT_ONE;
            end
            default: begin
                phase_len = CNT_ZERO;
            end
        endcase
    end
endfunction

// ----------------------------------------
// State and next-state signals
// ----------------------------------------
reg [2:0] state_q;
reg [2:0] state_d;
reg [`CNT_W-1:0] cnt_q;
reg [`CNT_W-1:0] cnt_d;
reg [`SEL_W-1:0] sel_q;
reg [`SEL_W-1:0] sel_d;
reg [`WORD_W-1:0] word_q;
reg [`WORD_W-1:0] word_d;
reg byte_q;
reg byte_d;
reg load_ready_d;
reg done_d;
reg [`WORD_W-1:0] bus_data_d;
reg [`NUM_DAC-1:0] decoded_select_n_d;
reg first_rank_load_n_d;
reg byte_latch_en_n_d;
reg output_update_d;

wire cnt_done = (cnt_q == CNT_ZERO);
// Load wins when both requests stand together
wire take_load = load_ready_o && load_valid_i;
wire take_update = load_ready_o && update_valid_i && !load_valid_i;

// ----------------------------------------
// Next-state logic
// ----------------------------------------
always @* begin
    state_d = state_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - CNT_ONE;
    sel_d = sel_q;
    word_d = word_q;
    byte_d = byte_q;
    load_ready_d = load_ready_o;
    done_d = 1'b0;
    bus_data_d = bus_data_o;
    decoded_select_n_d = decoded_select_n_o;
    first_rank_load_n_d = first_rank_load_n_o;
    byte_latch_en_n_d = byte_latch_en_n_o;
    output_update_d = output_update_o;
    case (state_q)
        ST_IDLE: begin
            load_ready_d = 1'b1;
            output_update_d = 1'b0;
            if (take_load) begin
                // Capture target before any select moves
                sel_d = load_sel_i;
                word_d = load_data_i;
                byte_d = byte_mode_i;
                load_ready_d = 1'b0;
                if (byte_mode_i) begin
                    bus_data_d = byte_on_bus(load_data_i[`WORD_W-1:`BYTE_W]);
                    state_d = ST_HI_SETUP;
                end else begin
                    bus_data_d = load_data_i;
                    state_d = ST_SETUP;
                end
            end else if (take_update) begin
                // No select needed; every converter moves at once
                load_ready_d = 1'b0;
                output_update_d = 1'b1;
                state_d = ST_UPDATE;
            end
        end
        ST_HI_SETUP: begin
            if (cnt_done) begin
                byte_latch_en_n_d = 1'b0;
                state_d = ST_HI_LATCH;
            end
        end
        ST_HI_LATCH: begin
            if (cnt_done) begin
                // Close the byte latch while the upper byte still stands
                byte_latch_en_n_d = `LATCH_IDLE;
                state_d = ST_SETUP;
            end
        end
        ST_SETUP: begin
            if (byte_q) begin
                bus_data_d = byte_on_bus(word_q[`BYTE_W-1:0]);
            end
            if (cnt_done) begin
                decoded_select_n_d = one_low(sel_q);
                first_rank_load_n_d = 1'b0;
                state_d = ST_STROBE;
            end
        end
        ST_STROBE: begin
            if (cnt_done) begin
                // Strobe rises first; select and data stay
                first_rank_load_n_d = `STROBE_IDLE;
                state_d = ST_HOLD;
            end
        end
        ST_HOLD: begin
            if (cnt_done) begin
                decoded_select_n_d = `SEL_IDLE;
                state_d = ST_SKEW;
            end
        end
        ST_UPDATE: begin
            if (cnt_done) begin
                output_update_d = `UPDATE_IDLE;
                state_d = ST_SKEW;
            end
        end
        ST_SKEW: begin
            // Gap between first-rank load and update, and between updates
            if (cnt_done) begin
                done_d = 1'b1;
                state_d = ST_IDLE;
            end
        end
        default: begin
            state_d = ST_IDLE;
        end
    endcase
    // Preload the counter on every change of state
    if (state_d != state_q) begin
        cnt_d = phase_len(state_d);
    end
end

// ----------------------------------------
// State register
// ----------------------------------------
always @(posedge clk_i) begin
    if (reset_i) begin
        state_q <= ST_IDLE;
    end else begin
        state_q <= state_d;
    end
end

// ----------------------------------------
// Phase counter
// ----------------------------------------
always @(posedge clk_i) begin
    if (reset_i) begin
        cnt_q <= CNT_ZERO;
    end else begin
        cnt_q <= cnt_d;
    end
end

// ----------------------------------------
// Captured request
// ----------------------------------------
always @(posedge clk_i) begin
    if (reset_i) begin
        sel_q <= {`SEL_W{1'b0}};
        word_q <= {`WORD_W{1'b0}};
        byte_q <= 1'b0;
    end else begin
        sel_q <= sel_d;
        word_q <= word_d;
        byte_q <= byte_d;
    end
end

// ----------------------------------------
// Host handshake outputs
// ----------------------------------------
always @(posedge clk_i) begin
    if (reset_i) begin
        load_ready_o <= 1'b0;
        done_o <= 1'b0;
    end else begin
        load_ready_o <= load_ready_d;
        done_o <= done_d;
    end
end

// ----------------------------------------
// Converter bus outputs
// ----------------------------------------
always @(posedge clk_i) begin
    if (reset_i) begin
        bus_data_o <= {`WORD_W{1'b0}};
        decoded_select_n_o <= `SEL_IDLE;
        first_rank_load_n_o <= `STROBE_IDLE;
        byte_latch_en_n_o <= `LATCH_IDLE;
    end else begin
        bus_data_o <= bus_data_d;
        decoded_select_n_o <= decoded_select_n_d;
        first_rank_load_n_o <= first_rank_load_n_d;
        byte_latch_en_n_o <= byte_latch_en_n_d;
    end
end

// ----------------------------------------
// Update line output
// ----------------------------------------
always @(posedge clk_i) begin
    if (reset_i) begin
        output_update_o <= `UPDATE_IDLE;
    end else begin
        output_update_o <= output_update_d;
    end
end

endmodule // dual_rank_dac_load_sequencer

/* File: tb/dac_load_seq_sva.sv */
`timescale 1ns/1ps
module dac_load_seq_sva(input wire clk_i, reset_i, load_valid_i, byte_mode_i, update_valid_i,
    load_ready_o, done_o, first_rank_load_n_o, byte_latch_en_n_o, output_update_o,
    input wire [1:0] load_sel_i, input wire [15:0] load_data_i, bus_data_o,
    input wire [3:0] decoded_select_n_o);
    wire u = output_update_o;
    wire s = first_rank_load_n_o;
    wire f = &decoded_select_n_o;
    wire t = load_ready_o && load_valid_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_upd; $rose(u) |-> ##9 u ##1 !u; endproperty
    a_upd: assert property (p_upd) else $error("update width");
    property p_cause; $rose(u) |-> $past(load_ready_o && update_valid_i && !load_valid_i); endproperty
    a_cause: assert property (p_cause) else $error("stray update");
    property p_hold; $rose(s) |-> !f [*5] ##1 f; endproperty
    a_hold: assert property (p_hold) else $error("select hold");
    property p_one; $countones(~decoded_select_n_o) <= 1; endproperty
    a_one: assert property (p_one) else $error("select not one-hot");
    property p_stab; !s |-> !f ##1 $stable(bus_data_o); endproperty
    a_stab: assert property (p_stab) else $error("strobe data");
    property p_lat; !byte_latch_en_n_o |-> s && f; endproperty
    a_lat: assert property (p_lat) else $error("byte latch overlap");
    property p_word; t && !byte_mode_i |-> ##31 done_o; endproperty
    a_word: assert property (p_word) else $error("word load length");
    property p_byte; t && byte_mode_i |-> ##46 done_o; endproperty
    a_byte: assert property (p_byte) else $error("byte load length");
    c_upd: cover property ($rose(u));
    c_byte: cover property ($fell(byte_latch_en_n_o));
    c_load: cover property ($fell(s));
endmodule // dac_load_seq_sva
bind dual_rank_dac_load_sequencer dac_load_seq_sva dac_load_seq_sva_i(.*);

/* File: tb/dac_model.sv */
`timescale 1ns/1ps
module dac_model(input wire [15:0] bus_data_o, input wire [3:0] decoded_select_n_o,
    input wire first_rank_load_n_o, byte_latch_en_n_o, output_update_o, byte_mode_i,
    output wire [63:0] dac_out_o);
    reg [7:0] hi;
    reg [15:0] r1 [0:3], r2 [0:3];
    always_latch if (!byte_latch_en_n_o) hi = bus_data_o[7:0];
    always @* for (int k = 0; k < 4; k++) begin
        if (!decoded_select_n_o[k] && !first_rank_load_n_o)
            r1[k] = byte_mode_i ? {hi, bus_data_o[7:0]} : bus_data_o;
        if (output_update_o) r2[k] = r1[k];
    end
    assign dac_out_o = {r2[3], r2[2], r2[1], r2[0]};
endmodule // dac_model

/* File: tb/dual_rank_dac_load_sequencer_bench.sv */
`timescale 1ns/1ps
module dual_rank_dac_load_sequencer_bench;
    reg clk_i = 0, reset_i = 1, load_valid_i = 0, byte_mode_i = 0, update_valid_i = 0;
    reg [1:0] load_sel_i = 2'h0;
    reg [15:0] load_data_i = 16'h0000;
    wire load_ready_o, done_o, first_rank_load_n_o, byte_latch_en_n_o, output_update_o;
    wire [15:0] bus_data_o;
    wire [3:0] decoded_select_n_o;
    wire [63:0] dac_out_o;
    int n_errors = 0, comparisons = 0;
    dual_rank_dac_load_sequencer dual_rank_dac_load_sequencer_i(.*);
    dac_model dac_model_i(.*);
    always #5 clk_i = ~clk_i;
    task chk(input string nm, input [63:0] e, s);
        comparisons++;
        if (e !== s) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Mode bits: load, update, byte
    task automatic go(input [2:0] m, input [1:0] sl, input [15:0] d, input int n);
        int k = 0;
        {load_valid_i, update_valid_i, byte_mode_i} <= m;
        load_sel_i <= sl;
        load_data_i <= d;
        @(posedge clk_i);
        while (load_ready_o !== 1'b1) @(posedge clk_i);
        load_valid_i <= 1'b0;
        update_valid_i <= 1'b0;
        do begin @(posedge clk_i); k++; end while (done_o !== 1'b1 && k < 99);
        chk("done cycles", n, k);
    endtask
    task t_word;
        go(3'h4, 2'h0, 16'h0000, 31);
        go(3'h4, 2'h1, 16'hFFFF, 31);
        go(3'h4, 2'h2, 16'h8000, 31);
        go(3'h4, 2'h3, 16'h1234, 31);
        go(3'h2, 2'h0, 16'h0000, 21);
        chk("dac outputs", 64'h1234_8000_FFFF_0000, dac_out_o);
        $display("t_word finished");
    endtask
    task t_byte;
        go(3'h6, 2'h1, 16'h5A5A, 31);
        go(3'h7, 2'h2, 16'hA5C3, 46);
        chk("held outputs", 64'h1234_8000_FFFF_0000, dac_out_o);
        go(3'h2, 2'h0, 16'h0000, 21);
        chk("byte word", 64'h1234_A5C3_5A5A_0000, dac_out_o);
        $display("t_byte finished");
    endtask
    task end_sim;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        t_word;
        t_byte;
        end_sim;
    end
    initial begin
        #20000;
        n_errors++;
        end_sim;
    end
endmodule // dual_rank_dac_load_sequencer_bench
